// File: rtl/dac_trig_pkg.sv
// Purpose: shared constants and types for the dac trigger block
// Assumes: 40 MHz system clock, apb with 32-bit data
// Notes: every offset, field position and count lives here, with the prescale, period and channel reset values
package dac_trig_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;
  // output trigger low time, ns, rounded down to whole cycles
  localparam int unsigned PULSE_LOW_NS = 125;
  localparam int unsigned PULSE_CYC_INT = (PULSE_LOW_NS * CLK_MHZ) / 1000;
  localparam logic [3:0] PULSE_CYC =
    4'((PULSE_CYC_INT < 1) ? 1 : PULSE_CYC_INT);
  // longest edge-to-start delay allowed, ns, rounded down
  localparam int unsigned START_MAX_NS = 6250;
  localparam int unsigned START_MAX_CYC = (START_MAX_NS * CLK_MHZ) / 1000;

  // channels and codes
  localparam int unsigned CHAN_COUNT = 8;
  localparam int unsigned CHAN_SMALL_BUILD = 4;
  localparam int unsigned CODE_W = 16;
  localparam logic [CODE_W-1:0] MIDSCALE_CODE = 16'h0000;

  // register byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_PRESCALE = 12'h004;
  localparam logic [11:0] ADDR_PERIOD = 12'h008;
  localparam logic [11:0] ADDR_START = 12'h00c;
  localparam logic [11:0] ADDR_STATUS = 12'h010;
  localparam logic [11:0] ADDR_CHAN_BASE = 12'h020;

  // control register fields
  localparam int unsigned CTRL_DIR_BIT = 0;
  localparam int unsigned CTRL_MODE_LSB = 1;
  localparam int unsigned CTRL_RUN_BIT = 3;
  // status register fields
  localparam int unsigned STAT_PIN_BIT = 0;
  localparam int unsigned STAT_DIR_BIT = 1;
  localparam int unsigned STAT_CNT_LSB = 16;

  // reset values
  localparam logic [7:0] PRESCALE_RST = 8'h00;
  localparam logic [15:0] PERIOD_RST = 16'h0064;

  // conversion modes
  typedef enum logic [1:0] {
    MODE_IDLE = 2'b00,
    MODE_SINGLE = 2'b01,
    MODE_TIMER = 2'b10,
    MODE_EXT = 2'b11
  } conv_mode_t;

  typedef logic [CHAN_COUNT-1:0][CODE_W-1:0] chan_bank_t;

  // whole state of the top module
  typedef struct packed {
    logic dir_out;
    conv_mode_t mode;
    logic timer_run;
    logic [7:0] prescale;
    logic [15:0] period;
    chan_bank_t chan;
    chan_bank_t dac;
    logic conv;
    logic [15:0] conv_cnt;
    logic [31:0] rdata;
    logic slverr;
  } top_state_t;

  // whole state of the trigger unit
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic [7:0] pre_cnt;
    logic [15:0] per_cnt;
    logic tick;
    logic [3:0] low_cnt;
    logic drive_low;
  } trig_state_t;

endpackage

// File: rtl/trig_if.sv
// Purpose: carries timer setup and trigger events between top and unit
// Assumes: one clock domain
// Notes: tick and ext_edge are one-cycle pulses
`timescale 1ns/1ps
interface trig_if;
  logic dir_out;
  logic timer_run;
  logic [7:0] prescale;
  logic [15:0] period;
  logic tick;
  logic ext_edge;
  logic pin_level;

  modport ctl (
    output dir_out, timer_run, prescale, period,
    input tick, ext_edge, pin_level
  );
  modport unit (
    input dir_out, timer_run, prescale, period,
    output tick, ext_edge, pin_level
  );
endinterface

// File: rtl/trig_unit.sv
// Purpose: trigger pin synchroniser, edge detector, interval timer, pulser
// Assumes: pin input synchronous enough for a two-stage synchroniser
// Notes: pin enable follows the direction bit only
`timescale 1ns/1ps
module trig_unit
  import dac_trig_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // shared trigger pin
  input wire logic pin_n_i,
  output logic pin_n_o,
  output logic pin_n_oe_o,
  // link to the control side
  trig_if.unit ctl
);

  trig_state_t s_q, s_d;

  // next-state logic
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    // two-stage synchroniser; only sync2 is looked at
    s_d.sync1 = pin_n_i;
    s_d.sync2 = s_q.sync1;
    s_d.prev = s_q.sync2;
    // interval timer: prescaler then period countdown
    if (!ctl.timer_run) begin
      s_d.pre_cnt = 8'h00;
      s_d.per_cnt = ctl.period;
    end else if (s_q.pre_cnt == ctl.prescale) begin
      s_d.pre_cnt = 8'h00;
      if (s_q.per_cnt == 16'h0000) begin
        s_d.per_cnt = ctl.period;
        s_d.tick = 1'b1;
      end else begin
        s_d.per_cnt = s_q.per_cnt - 16'h0001;
      end
    end else begin
      s_d.pre_cnt = s_q.pre_cnt + 8'h01;
    end
    // low pulse on each timer tick, only while the pin is an output
    if (!ctl.dir_out) begin
      s_d.low_cnt = 4'h0;
    end else if (s_q.tick) begin
      s_d.low_cnt = PULSE_CYC;
    end else if (s_q.low_cnt != 4'h0) begin
      s_d.low_cnt = s_q.low_cnt - 4'h1;
    end
    s_d.drive_low = (s_d.low_cnt != 4'h0);
  end

  // state register
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      s_q <= '{sync1: 1'b1, sync2: 1'b1, prev: 1'b1, pre_cnt: 8'h00,
               per_cnt: 16'h0000, tick: 1'b0, low_cnt: 4'h0,
               drive_low: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // falling edge only, so a long low starts one conversion
  assign ctl.ext_edge = s_q.prev & ~s_q.sync2;
  assign ctl.tick = s_q.tick;
  assign ctl.pin_level = s_q.sync2;
  assign pin_n_o = ~s_q.drive_low;
  assign pin_n_oe_o = ctl.dir_out;

endmodule // trig_unit

// File: rtl/dac_trig_top.sv
// Purpose: apb register block and conversion control for the dac trigger
// Assumes: apb3 master, 40 MHz clock, synchronous active-low reset
// Notes: zero wait-state apb; read data is captured in the setup cycle
`timescale 1ns/1ps
module dac_trig_top
  import dac_trig_pkg::*;
#(
  parameter bit EIGHT_CH_BUILD = 1'b1
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // shared trigger pin
  input wire logic sync_pulse_pin_n_i,
  output logic sync_pulse_pin_n_o,
  output logic sync_pulse_pin_n_oe_o,
  // dac side
  output logic conv_start_o,
  output chan_bank_t twos_complement_code_o
);

  top_state_t s_q, s_d;
  trig_if tif ();

  // true when the address names a channel present in this build
  function automatic logic is_chan(input logic [11:0] a);
    logic [11:0] top_addr;
    top_addr = ADDR_CHAN_BASE + 12'(4 * CHAN_COUNT);
    if (!EIGHT_CH_BUILD) begin
      top_addr = ADDR_CHAN_BASE + 12'(4 * CHAN_SMALL_BUILD);
    end
    is_chan = (a >= ADDR_CHAN_BASE) && (a < top_addr) && (a[1:0] == 2'b00);
  endfunction

  // channel number from a channel address
  function automatic logic [2:0] chan_of(input logic [11:0] a);
    logic [11:0] off;
    off = a - ADDR_CHAN_BASE;
    chan_of = off[4:2];
  endfunction

  // one code per register, decoded once and shared by writes, reads
  // and the error flag, so the three can never disagree
  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_CTRL = 3'b001,
    SEL_PRESCALE = 3'b010,
    SEL_PERIOD = 3'b011,
    SEL_START = 3'b100,
    SEL_STATUS = 3'b101,
    SEL_CHAN = 3'b110
  } reg_sel_t;

  // register named by an address, none for a hole in the map
  function automatic reg_sel_t reg_sel(input logic [11:0] a);
    reg_sel = SEL_NONE;
    if (a == ADDR_CTRL) begin
      reg_sel = SEL_CTRL;
    end
    if (a == ADDR_PRESCALE) begin
      reg_sel = SEL_PRESCALE;
    end
    if (a == ADDR_PERIOD) begin
      reg_sel = SEL_PERIOD;
    end
    if (a == ADDR_START) begin
      reg_sel = SEL_START;
    end
    if (a == ADDR_STATUS) begin
      reg_sel = SEL_STATUS;
    end
    if (is_chan(a)) begin
      reg_sel = SEL_CHAN;
    end
  endfunction

  logic setup_phase;
  logic wr_go;
  logic start_wr;
  logic conv_go;
  logic mapped;
  reg_sel_t sel;

  // apb phase decode
  assign setup_phase = psel_i & ~penable_i;
  assign wr_go = psel_i & penable_i & pwrite_i;
  assign sel = reg_sel(paddr_i);
  assign start_wr = wr_go && (sel == SEL_START);
  assign mapped = (sel != SEL_NONE);

  // conversion sources, one per mode; a timer tick never converts
  // in external mode, so chained modules follow only the pin
  always_comb begin
    conv_go = 1'b0;
    unique case (s_q.mode)
      MODE_IDLE: conv_go = 1'b0;
      MODE_SINGLE: conv_go = start_wr;
      MODE_TIMER: conv_go = tif.tick;
      MODE_EXT: conv_go = tif.ext_edge & ~s_q.dir_out;
    endcase
  end

  // next-state logic: registers, read capture and conversion
  always_comb begin
    s_d = s_q;
    s_d.conv = conv_go;
    // writes take effect in the access cycle only
    if (wr_go) begin
      if (sel == SEL_CTRL) begin
        s_d.dir_out = pwdata_i[CTRL_DIR_BIT];
        s_d.mode = conv_mode_t'(pwdata_i[CTRL_MODE_LSB +: 2]);
        s_d.timer_run = pwdata_i[CTRL_RUN_BIT];
      end
      if (sel == SEL_PRESCALE) begin
        s_d.prescale = pwdata_i[7:0];
      end
      if (sel == SEL_PERIOD) begin
        s_d.period = pwdata_i[15:0];
      end
      if (sel == SEL_CHAN) begin
        s_d.chan[chan_of(paddr_i)] = pwdata_i[CODE_W-1:0];
      end
    end
    // conversion copies the held codes; a same-cycle write lands next time
    if (conv_go) begin
      s_d.dac = s_q.chan;
      s_d.conv_cnt = s_q.conv_cnt + 16'h0001;
    end
    // read data and error are fixed in setup so they come from flops
    if (setup_phase) begin
      s_d.rdata = 32'h0000_0000;
      s_d.slverr = ~mapped;
      if (sel == SEL_CTRL) begin
        s_d.rdata[CTRL_DIR_BIT] = s_q.dir_out;
        s_d.rdata[CTRL_MODE_LSB +: 2] = s_q.mode;
        s_d.rdata[CTRL_RUN_BIT] = s_q.timer_run;
      end
      if (sel == SEL_PRESCALE) begin
        s_d.rdata[7:0] = s_q.prescale;
      end
      if (sel == SEL_PERIOD) begin
        s_d.rdata[15:0] = s_q.period;
      end
      if (sel == SEL_STATUS) begin
        s_d.rdata[STAT_PIN_BIT] = tif.pin_level;
        s_d.rdata[STAT_DIR_BIT] = s_q.dir_out;
        s_d.rdata[STAT_CNT_LSB +: 16] = s_q.conv_cnt;
      end
      if (sel == SEL_CHAN) begin
        s_d.rdata[CODE_W-1:0] = s_q.chan[chan_of(paddr_i)];
      end
    end
  end

  // state register; reset puts every channel at midscale
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      s_q.dir_out <= 1'b0;
      s_q.mode <= MODE_IDLE;
      s_q.timer_run <= 1'b0;
      s_q.prescale <= PRESCALE_RST;
      s_q.period <= PERIOD_RST;
      s_q.chan <= {CHAN_COUNT{MIDSCALE_CODE}};
      s_q.dac <= {CHAN_COUNT{MIDSCALE_CODE}};
      s_q.conv <= 1'b0;
      s_q.conv_cnt <= 16'h0000;
      s_q.rdata <= 32'h0000_0000;
      s_q.slverr <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // timer only runs in timer mode, so stale setup cannot pulse the pin
  assign tif.dir_out = s_q.dir_out;
  assign tif.timer_run = s_q.timer_run & (s_q.mode == MODE_TIMER);
  assign tif.prescale = s_q.prescale;
  assign tif.period = s_q.period;

  // pin handling and timer
  trig_unit i_trig_unit (
    .sys_clk_i (sys_clk_i),
    .rst_n_i (rst_n_i),
    .pin_n_i (sync_pulse_pin_n_i),
    .pin_n_o (sync_pulse_pin_n_o),
    .pin_n_oe_o (sync_pulse_pin_n_oe_o),
    .ctl (tif.ctl)
  );

  // outputs; absent channels in the small build read and drive zero
  assign prdata_o = s_q.rdata;
  assign pslverr_o = s_q.slverr & psel_i & penable_i;
  assign pready_o = 1'b1;
  assign conv_start_o = s_q.conv;
  // absent channels of the small build hold midscale on the pins, so a
  // four-channel part never shows a code that software cannot reach
  for (genvar g = 0; g < CHAN_COUNT; g++) begin : g_code_out
    if (EIGHT_CH_BUILD || (g < CHAN_SMALL_BUILD)) begin : g_present
      assign twos_complement_code_o[g] = s_q.dac[g];
    end else begin : g_absent
      assign twos_complement_code_o[g] = MIDSCALE_CODE;
    end
  end

endmodule // dac_trig_top

// File: testbench/dac_trig_properties.sv
// Purpose: port timing checks for the dac trigger top
// Assumes: ctrl resets to zero (input, idle)
// Notes: ctrl is shadowed from apb writes
`timescale 1ns/1ps
module dac_trig_properties
  import dac_trig_pkg::*;
(
  // clock, reset, apb
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  // pin and dac side
  input wire logic sync_pulse_pin_n_i,
  input wire logic sync_pulse_pin_n_o,
  input wire logic sync_pulse_pin_n_oe_o,
  input wire logic conv_start_o,
  input wire chan_bank_t twos_complement_code_o
);
  logic [3:0] ctl_q;
  logic ext_in;
  // shadow ctrl, written at the same edge as the design's copy
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) ctl_q <= 4'h0;
    else if (psel_i && penable_i && pwrite_i && paddr_i == ADDR_CTRL)
      ctl_q <= pwdata_i[3:0];
  end
  assign ext_in = (ctl_q[2:0] == 3'b110);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // rest of a five-cycle low pulse
  sequence low_rest;
    (!sync_pulse_pin_n_o)[*4] ##1 sync_pulse_pin_n_o;
  endsequence
  pulse_width_a: assert property ($fell(sync_pulse_pin_n_o) |=> low_rest)
    else $error("pulse width wrong");
  pulse_conv_a: assert property ($fell(sync_pulse_pin_n_o) |-> conv_start_o)
    else $error("pulse without conversion");
  drive_oe_a: assert property (!sync_pulse_pin_n_o |-> sync_pulse_pin_n_oe_o)
    else $error("low driven without enable");
  input_quiet_a: assert property (!ctl_q[0] && !$past(ctl_q[0])
    |-> !sync_pulse_pin_n_oe_o)
    else $error("driver on in input mode");
  ext_start_a: assert property (ext_in && $fell(sync_pulse_pin_n_i)
    |-> ##[2:4] conv_start_o)
    else $error("no conversion after edge");
  no_retrig_a: assert property ((ext_in && !sync_pulse_pin_n_i)[*8]
    |-> !conv_start_o)
    else $error("retrigger while low");
  one_pulse_a: assert property (conv_start_o |=> !conv_start_o)
    else $error("start longer than a cycle");
  code_latch_a: assert property ($changed(twos_complement_code_o)
    |-> conv_start_o)
    else $error("codes moved without start");
  midscale_a: assert property ($rose(rst_n_i)
    |-> twos_complement_code_o == {CHAN_COUNT{MIDSCALE_CODE}})
    else $error("codes not midscale");
endmodule // dac_trig_properties

// File: testbench/ext_trig_src.sv
// Purpose: external event source on the trigger line
// Assumes: line pulled up, so released reads high
// Notes: low time per request, in cycles
`timescale 1ns/1ps
module ext_trig_src (
  // clock and request
  input wire logic sys_clk_i,
  input wire logic fire_i,
  input wire logic [9:0] low_cyc_i,
  // open-drain drive
  output logic pin_n_o
);
  logic [9:0] cnt_q = '0;
  // hold low for the span, then let the pull-up win
  always @(posedge sys_clk_i) begin
    if (fire_i) cnt_q <= low_cyc_i;
    else if (cnt_q != 0) cnt_q <= cnt_q - 10'h001;
  end
  assign pin_n_o = (cnt_q == 0);
endmodule // ext_trig_src

// File: testbench/dac_trig_top_tb.sv
// Purpose: apb-driven checks of the dac trigger top
// Assumes: zero wait-state apb, 40 MHz clock
// Notes: a four-channel build shares the bus
`timescale 1ns/1ps
module dac_trig_top_tb;
  import dac_trig_pkg::*;
  logic sys_clk_i = 0, rst_n_i = 0, psel = 0, pen = 0, pwr = 0, fire = 0;
  logic [11:0] addr = '0;
  logic [31:0] wd = '0, rd, rd4, r, r4;
  logic [9:0] low_cyc = '0;
  logic rdy, err, err4, pin_o, oe, conv, ext_n, line, e, e4;
  chan_bank_t code;
  int n_errors = 0, compares = 0, n_conv = 0, w;
  // line level: pull-up unless someone drives it
  assign line = oe ? pin_o : ext_n;
  dac_trig_top i_dac_trig_top (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(addr),
    .pwdata_i(wd), .prdata_o(rd), .pready_o(rdy), .pslverr_o(err),
    .sync_pulse_pin_n_i(line), .sync_pulse_pin_n_o(pin_o),
    .sync_pulse_pin_n_oe_o(oe), .conv_start_o(conv),
    .twos_complement_code_o(code));
  dac_trig_top #(.EIGHT_CH_BUILD(1'b0)) i_dac_trig_top_4 (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(addr), .pwdata_i(wd),
    .prdata_o(rd4), .pready_o(), .pslverr_o(err4),
    .sync_pulse_pin_n_i(1'b1), .sync_pulse_pin_n_o(),
    .sync_pulse_pin_n_oe_o(), .conv_start_o(),
    .twos_complement_code_o());
  ext_trig_src i_ext_trig_src (.sys_clk_i(sys_clk_i), .fire_i(fire),
    .low_cyc_i(low_cyc), .pin_n_o(ext_n));
  initial begin
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  // conversions seen at the dac side
  always @(posedge sys_clk_i) if (conv === 1'b1) n_conv <= n_conv + 1;
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge sys_clk_i);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    addr <= a;
    wd <= d;
    @(posedge sys_clk_i);
    pen <= 1'b1;
    do @(posedge sys_clk_i); while (rdy !== 1'b1);
    r = rd;
    r4 = rd4;
    e = err;
    e4 = err4;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic trig(input logic [9:0] n);
    @(posedge sys_clk_i);
    fire <= 1'b1;
    low_cyc <= n;
    @(posedge sys_clk_i);
    fire <= 1'b0;
    repeat (START_MAX_CYC) @(posedge sys_clk_i);
  endtask
  task automatic tally_and_finish;
    if (n_errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // watchdog, well past the expected run
  initial begin
    #500000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (4) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, ADDR_CHAN_BASE + 12'(4 * i), '0);
      chk(r, '0);
      chk({16'h0, code[i]}, '0);
    end
    chk({31'h0, oe}, '0);
    // channel mapping in the two builds, plus an unmapped word
    apb(1'b1, ADDR_CHAN_BASE + 12'h01c, 32'h1234);
    apb(1'b1, ADDR_CHAN_BASE + 12'h00c, 32'h0033);
    apb(1'b0, ADDR_CHAN_BASE + 12'h01c, '0);
    chk(r, 32'h1234);
    chk({31'h0, e4}, 32'h1);
    apb(1'b0, ADDR_CHAN_BASE + 12'h00c, '0);
    chk(r4, 32'h0033);
    apb(1'b0, 12'h0fc, '0);
    chk({31'h0, e}, 32'h1);
    // single conversion of the code extremes
    apb(1'b1, ADDR_CHAN_BASE, 32'h8000);
    apb(1'b1, ADDR_CHAN_BASE + 12'h004, 32'h7fff);
    apb(1'b1, ADDR_CTRL, 32'h2);
    apb(1'b1, ADDR_START, '0);
    repeat (4) @(posedge sys_clk_i);
    chk(n_conv, 1);
    chk({16'h0, code[0]}, 32'h8000);
    chk({16'h0, code[1]}, 32'h7fff);
    chk({16'h0, code[7]}, 32'h1234);
    // external trigger, ten-cycle then 200-cycle low
    apb(1'b1, ADDR_CTRL, 32'h6);
    trig(10'd10);
    chk(n_conv, 2);
    apb(1'b1, ADDR_CHAN_BASE, 32'h0001);
    trig(10'd200);
    chk(n_conv, 3);
    chk({16'h0, code[0]}, 32'h0001);
    // status: pin idle high, input direction, three and one conversions
    apb(1'b0, ADDR_STATUS, '0);
    chk(r, 32'h0003_0001);
    chk(r4, 32'h0001_0001);
    chk({31'h0, oe}, '0);
    // timer pulses driven out, tick every ten cycles
    apb(1'b1, ADDR_PRESCALE, 32'h1);
    apb(1'b1, ADDR_PERIOD, 32'h4);
    apb(1'b1, ADDR_CTRL, 32'hd);
    w = 0;
    while (line !== 1'b0 && w < 400) begin
      @(posedge sys_clk_i);
      w++;
    end
    w = 0;
    while (line === 1'b0 && w < 20) begin
      @(posedge sys_clk_i);
      w++;
    end
    chk(w, 5);
    chk({31'h0, oe}, 32'h1);
    apb(1'b1, ADDR_CTRL, '0);
    tally_and_finish();
  end
endmodule // dac_trig_top_tb
bind dac_trig_top dac_trig_properties i_dac_trig_properties (.*);
